// [shared/oepd_cfg.svh]
// Constants for the output enable and power-down block
`ifndef OEPD_CFG_SVH
`define OEPD_CFG_SVH

// =====================================================
// Sizes
`define OEPD_NUM_OUT 3
`define OEPD_DIV_W 8

// =====================================================
// Output index of the differential pair members
`define OEPD_PAIR_FIRST 0
`define OEPD_PAIR_SECOND 1

// =====================================================
// Reset values
`define OEPD_SYNC_RST 1'h0
`define OEPD_PHASE_RST 1'h0
`define OEPD_EN_RST 1'h0
`define OEPD_CLK_RST 1'h0
`define OEPD_OE_N_RST 1'h0
`define OEPD_CNT_RST 8'h00
`define OEPD_MASK_RST 3'h0
`define OEPD_HIZ_RST 3'h0
`define OEPD_DIFF_RST 1'h0
`define OEPD_HALF_RST 24'h01_0101

`endif

// [shared/oepd_pkg.sv]
// Types shared by the output enable and power-down block
`include "oepd_cfg.svh"

package oepd_pkg;

    // =====================================================
    // Configuration space image
    typedef struct packed {
        logic [`OEPD_NUM_OUT-1:0] out_en;
        logic [`OEPD_NUM_OUT-1:0] hiz_sel;
        logic diff_mode;
        logic [`OEPD_NUM_OUT*`OEPD_DIV_W-1:0] half;
    } oepd_cfg_t;

    // =====================================================
    // Per-output pin group
    typedef struct packed {
        logic [`OEPD_NUM_OUT-1:0] clk;
        logic [`OEPD_NUM_OUT-1:0] oe_n;
    } oepd_pins_t;

endpackage

// [design/oepd_gate.sv]
// One clock output: divider, glitch-free gate and disabled-state driver
`timescale 1ns/1ps
`include "oepd_cfg.svh"

module oepd_gate #(
    parameter int DIV_W = `OEPD_DIV_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic [DIV_W-1:0] half_i,
    input wire logic en_req_i,
    input wire logic hiz_sel_i,
    output logic clk_o,
    output logic oe_n_o
);
    import oepd_pkg::*;

    logic [DIV_W-1:0] cnt_reg, cnt_next;
    logic phase_reg, phase_next;
    logic en_reg, en_next;
    logic clk_reg, clk_next;
    logic oe_n_reg, oe_n_next;
    logic [DIV_W:0] cnt_inc;
    logic wrap;

    // =====================================================
    // Divider and gate next state
    always_comb begin
        cnt_inc = {1'b0, cnt_reg} + (DIV_W+1)'(1);
        wrap = cnt_inc >= {1'b0, half_i};
        cnt_next = cnt_reg;
        phase_next = phase_reg;
        en_next = en_reg;
        // Divider runs whatever the enable does
        if (wrap) begin
            cnt_next = `OEPD_CNT_RST;
            phase_next = ~phase_reg;
        end else begin
            cnt_next = cnt_inc[DIV_W-1:0];
        end
        // Enable only moves while the output is low, so pulses stay whole
        if (!phase_reg) begin
            en_next = en_req_i;
        end
        clk_next = phase_next & en_next;
        // Disabled output is Hi-Z or driven low
        oe_n_next = ~en_next & hiz_sel_i;
        // Power-down holds everything cleared, outputs driven low
        if (!run_i) begin
            cnt_next = `OEPD_CNT_RST;
            phase_next = `OEPD_PHASE_RST;
            en_next = `OEPD_EN_RST;
            clk_next = `OEPD_CLK_RST;
            oe_n_next = `OEPD_OE_N_RST;
        end
    end

    // Registers, frozen while the clock enable is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= `OEPD_CNT_RST;
            phase_reg <= `OEPD_PHASE_RST;
            en_reg <= `OEPD_EN_RST;
            clk_reg <= `OEPD_CLK_RST;
            oe_n_reg <= `OEPD_OE_N_RST;
        end else if (ce_i) begin
            cnt_reg <= cnt_next;
            phase_reg <= phase_next;
            en_reg <= en_next;
            clk_reg <= clk_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign clk_o = clk_reg;
    assign oe_n_o = oe_n_reg;

    // =====================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    clock_pulse_whole_a: assert property (clk_reg |-> phase_reg && en_reg)
        else $error("output high outside an enabled high phase");
    enable_change_low_a: assert property (
        $changed(en_reg) |-> !$past(phase_reg) || !$past(run_i))
        else $error("enable moved during a high phase");
    divider_free_a: assert property (
        ce_i && run_i && wrap |=> $changed(phase_reg))
        else $error("divider stalled");
    disabled_drive_a: assert property (
        run_i && ce_i && !en_next |=> !clk_o && oe_n_o == $past(hiz_sel_i))
        else $error("wrong disabled state");
    pulse_seen_c: cover property (en_reg ##1 clk_reg ##1 !clk_reg);
endmodule

// [design/oepd_top.sv]
// Output enable gating and power-down control for a three-output clock generator
`timescale 1ns/1ps
`include "oepd_cfg.svh"

module oepd_top #(
    parameter int NUM_OUT = `OEPD_NUM_OUT,
    parameter int DIV_W = `OEPD_DIV_W
) (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    input wire logic [NUM_OUT-1:0] GATE_PIN_I,
    input wire logic SLEEP_RESET_N_I,
    input wire logic CFG_WR_I,
    input wire oepd_pkg::oepd_cfg_t CFG_I,
    output oepd_pkg::oepd_cfg_t CFG_O,
    output logic ACTIVE_O,
    output oepd_pkg::oepd_pins_t PINS_O
);
    import oepd_pkg::*;

    // =====================================================
    // Signals
    logic [NUM_OUT-1:0] pin_s1_reg, pin_s1_next;
    logic [NUM_OUT-1:0] pin_s2_reg, pin_s2_next;
    logic sleep_s1_reg, sleep_s1_next;
    logic sleep_s2_reg, sleep_s2_next;
    oepd_cfg_t cfg_reg, cfg_next;
    logic [NUM_OUT-1:0] en_req;
    logic [NUM_OUT-1:0] gate_clk;
    logic [NUM_OUT-1:0] gate_oe_n;
    logic run;

    // =====================================================
    // Functions

    // Pin that gates output k in the current mode
    function automatic logic pin_for(
        input logic [NUM_OUT-1:0] pins,
        input logic diff,
        input int k
    );
        logic sel;
        sel = pins[k];
        if (diff && k == `OEPD_PAIR_FIRST) begin
            sel = pins[`OEPD_PAIR_SECOND];
        end
        return sel;
    endfunction

    // Configuration enable bit for output k in the current mode
    function automatic logic cfg_for(
        input logic [NUM_OUT-1:0] ens,
        input logic diff,
        input int k
    );
        logic sel;
        sel = ens[k];
        if (diff && k == `OEPD_PAIR_FIRST) begin
            sel = ens[`OEPD_PAIR_SECOND];
        end
        return sel;
    endfunction

    // =====================================================
    // Input synchronisers

    // Two stages for the enable pins and the sleep pin
    always_comb begin
        pin_s1_next = GATE_PIN_I;
        pin_s2_next = pin_s1_reg;
        sleep_s1_next = SLEEP_RESET_N_I;
        sleep_s2_next = sleep_s1_reg;
    end

    // Sleep stages reset to asleep until the pin is seen high
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            pin_s1_reg <= {NUM_OUT{`OEPD_SYNC_RST}};
            pin_s2_reg <= {NUM_OUT{`OEPD_SYNC_RST}};
            sleep_s1_reg <= `OEPD_SYNC_RST;
            sleep_s2_reg <= `OEPD_SYNC_RST;
        end else if (CE_I) begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
            sleep_s1_reg <= sleep_s1_next;
            sleep_s2_reg <= sleep_s2_next;
        end
    end

    // Device runs only while the synchronised sleep input is high
    assign run = sleep_s2_reg;

    // =====================================================
    // Configuration space

    // Every write from the master made while the clock enable is high is stored whole
    always_comb begin
        cfg_next = cfg_reg;
        if (CFG_WR_I) begin
            cfg_next = CFG_I;
        end
    end

    // Configuration is kept across power-down; only system reset clears it
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            cfg_reg.out_en <= `OEPD_MASK_RST;
            cfg_reg.hiz_sel <= `OEPD_HIZ_RST;
            cfg_reg.diff_mode <= `OEPD_DIFF_RST;
            cfg_reg.half <= `OEPD_HALF_RST;
        end else if (CE_I) begin
            cfg_reg <= cfg_next;
        end
    end

    // =====================================================
    // Enable combination and output slices
    generate
        for (genvar k = 0; k < NUM_OUT; k++) begin : g_out
            // Both the config bit and the own pin must allow the output
            // Pair follows the second pin in differential mode
            // Each pin reaches only its own slice, except the second pin, which also gates the first slice in differential mode
            assign en_req[k] = cfg_for(cfg_reg.out_en, cfg_reg.diff_mode, k)
                             & pin_for(pin_s2_reg, cfg_reg.diff_mode, k);

            // Divider and glitch-free gate for output k
            oepd_gate #(
                .DIV_W(DIV_W)
            ) u_gate (
                .clk_i(SYS_CLK_I),
                .rst_i(SYS_RST_I),
                .ce_i(CE_I),
                .run_i(run),
                .half_i(cfg_reg.half[k*DIV_W +: DIV_W]),
                .en_req_i(en_req[k]),
                .hiz_sel_i(cfg_reg.hiz_sel[k]),
                .clk_o(gate_clk[k]),
                .oe_n_o(gate_oe_n[k])
            );
        end
    endgenerate

    // =====================================================
    // Outputs
    // Pin group packs the gated clocks with their driver enables
    assign PINS_O = '{clk: gate_clk, oe_n: gate_oe_n};
    assign CFG_O = cfg_reg;
    assign ACTIVE_O = run;

    // =====================================================
    // Checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    // Power-down forces every output low and driven
    sleep_outputs_low_a: assert property (CE_I && !run |=> PINS_O == '0)
        else $error("outputs not low in power-down");

    // Power-down persists until the pin has been high for two edges
    sleep_default_off_a: assert property ($rose(run) |-> $past(sleep_s1_reg))
        else $error("woke without a high sleep input");

    // A write lands in the configuration space on the next edge
    cfg_write_taken_a: assert property (
        CE_I && CFG_WR_I |=> cfg_reg == $past(CFG_I))
        else $error("configuration write lost");

    // Without a write the stored configuration holds
    cfg_held_a: assert property (CE_I && !CFG_WR_I |=> $stable(cfg_reg))
        else $error("configuration moved without a write");

    // A cleared config bit keeps the output disabled
    cfg_bit_blocks_a: assert property (
        !cfg_reg.diff_mode && !cfg_reg.out_en[2] |-> !en_req[2])
        else $error("output enabled against config");

    // Config bit and pin together raise the request
    both_allow_a: assert property (
        !cfg_reg.diff_mode && cfg_reg.out_en[2] && pin_s2_reg[2] |-> en_req[2])
        else $error("output blocked although both enables are set");

    // Each low pin blocks its own output, the pair's first half excepted
    for (genvar k = 0; k < NUM_OUT; k++) begin : g_chk
        own_pin_each_a: assert property (
            !(cfg_reg.diff_mode && k == `OEPD_PAIR_FIRST) && !pin_s2_reg[k] |-> !en_req[k])
            else $error("low pin did not block its output");
    end

    // The first pin has no say over the pair
    first_pin_ignored_a: assert property (
        cfg_reg.diff_mode |-> en_req[0] == (cfg_reg.out_en[1] & pin_s2_reg[1]))
        else $error("first pin reached the differential pair");

    // Low third pin blocks only the third output
    own_pin_blocks_a: assert property (!pin_s2_reg[2] |-> !en_req[2])
        else $error("third pin did not gate its output");

    // Differential pair follows one request
    pair_follows_a: assert property (cfg_reg.diff_mode |-> en_req[0] == en_req[1])
        else $error("pair halves gated apart");

    // Scenario coverage
    wake_up_c: cover property (!run ##1 run);
    diff_pair_c: cover property (cfg_reg.diff_mode && !pin_s2_reg[0] && en_req[0]);
    hiz_disable_c: cover property (run && PINS_O.oe_n[2]);
    sleep_entry_c: cover property (run ##1 !run);
endmodule

// [tb/oepd_master.sv]
// Model of the serial-bus master that loads the configuration space
`timescale 1ns/1ps

module oepd_master #(
    parameter int SETTLE = 4
) (
    input wire logic clk_i,
    output logic wr_o,
    output oepd_pkg::oepd_cfg_t cfg_o
);
    import oepd_pkg::*;

    // ==========================================
    // Write access
    initial begin
        wr_o = 1'b0;
        cfg_o = '0;
    end

    // One-beat write, then the data lines stop showing the written value
    task automatic write_cfg(input oepd_cfg_t c);
        @(posedge clk_i);
        wr_o <= 1'b1;
        cfg_o <= c;
        @(posedge clk_i);
        wr_o <= 1'b0;
        cfg_o <= ~c;
        // Relock allowance before the clocks are trusted
        repeat (SETTLE) @(posedge clk_i);
    endtask
endmodule

// [tb/tb_output_enable_power_down.sv]
// Self-checking bench for the output enable and power-down block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module tb_output_enable_power_down;
    import oepd_pkg::*;

    logic sys_clk, sys_rst, ce, sleep_n, cfg_wr, active;
    logic [2:0] gate_pin;
    oepd_cfg_t cfg_in, cfg_out, cur;
    oepd_pins_t pins;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int w;
    localparam int MAX_CYCLES = 6000;

    oepd_top i_dut (.SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .CE_I(ce),
        .GATE_PIN_I(gate_pin), .SLEEP_RESET_N_I(sleep_n), .CFG_WR_I(cfg_wr),
        .CFG_I(cfg_in), .CFG_O(cfg_out), .ACTIVE_O(active), .PINS_O(pins));
    oepd_master i_mst (.clk_i(sys_clk), .wr_o(cfg_wr), .cfg_o(cfg_in));

    // ==========================================
    // Clock, watchdog and helpers
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == MAX_CYCLES) begin
            errors++;
            summarize();
        end
    end

    function automatic oepd_cfg_t mk(logic [2:0] en, logic [2:0] hiz, logic diff, logic [23:0] h);
        mk = '{out_en: en, hiz_sel: hiz, diff_mode: diff, half: h};
    endfunction

    function automatic logic exp_en(oepd_cfg_t c, logic [2:0] p, int k);
        int j;
        j = (c.diff_mode && k == 0) ? 1 : k;
        return c.out_en[j] & p[j];
    endfunction

    task automatic wr(input oepd_cfg_t c);
        cur = c;
        i_mst.write_cfg(c);
        #1;
        `CHK(cfg_out, c)
    endtask

    task automatic drive(input logic [2:0] p, input logic s);
        @(posedge sys_clk);
        gate_pin <= p;
        sleep_n <= s;
    endtask

    // Settle, then judge each output over two cycles (half period of one)
    task automatic check_outs();
        logic [2:0] c1;
        repeat (8) @(posedge sys_clk);
        #1 c1 = pins.clk;
        @(posedge sys_clk);
        #1;
        for (int k = 0; k < 3; k++) begin
            if (exp_en(cur, gate_pin, k)) begin
                `CHK(pins.oe_n[k], 1'b0)
                `CHK(pins.clk[k], ~c1[k])
            end else begin
                `CHK(pins.oe_n[k], cur.hiz_sel[k])
                `CHK(pins.clk[k] | c1[k], 1'b0)
            end
        end
    endtask

    // High time of output 2 sampled after each edge, optionally dropping its pin mid-pulse
    task automatic pulse_width(input logic drop, output int n);
        int i;
        i = 0;
        n = 0;
        #1;
        while (i < 40 && pins.clk[2] !== 1'b0) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        while (i < 40 && pins.clk[2] !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        while (n < 20 && pins.clk[2] === 1'b1) begin
            @(posedge sys_clk);
            if (drop) gate_pin <= 3'h3;
            #1;
            n++;
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        #1;
        `CHK(cfg_out, mk(3'h0, 3'h0, 1'b0, 24'h01_0101))
        `CHK(pins, 6'h00)
        `CHK(active, 1'b0)
    endtask

    task automatic t_asleep();
        wr(mk(3'h7, 3'h7, 1'b0, 24'h01_0101));
        drive(3'h7, 1'b0);
        repeat (8) @(posedge sys_clk);
        #1;
        `CHK(active, 1'b0)
        `CHK(pins, 6'h00)
    endtask

    task automatic t_wake();
        oepd_pins_t snap;
        drive(3'h7, 1'b1);
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK(active, 1'b1)
        check_outs();
        // Clock enable low freezes the toggling outputs
        @(posedge sys_clk);
        ce <= 1'b0;
        @(posedge sys_clk);
        #1 snap = pins;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK(pins, snap)
        @(posedge sys_clk);
        ce <= 1'b1;
    endtask

    task automatic t_gating();
        for (int k = 0; k < 3; k++) begin
            wr(mk(3'h7, 3'h5, 1'b0, 24'h01_0101));
            drive(3'h1 << k, 1'b1);
            check_outs();
            wr(mk(3'h1 << k, 3'h5, 1'b0, 24'h01_0101));
            drive(3'h7, 1'b1);
            check_outs();
        end
    endtask

    task automatic t_diff();
        logic [2:0] pat [4] = '{3'h1, 3'h2, 3'h6, 3'h5};
        wr(mk(3'h3, 3'h2, 1'b1, 24'h01_0101));
        for (int i = 0; i < 4; i++) begin
            drive(pat[i], 1'b1);
            check_outs();
        end
    endtask

    // Output 2 runs four cycles high; a pin dropped mid-pulse must not cut it
    task automatic t_glitch();
        logic c0;
        wr(mk(3'h7, 3'h4, 1'b0, 24'h04_0101));
        drive(3'h3, 1'b1);
        repeat (10) @(posedge sys_clk);
        gate_pin <= 3'h7;
        pulse_width(1'b0, w);
        `CHK(w, 4)
        pulse_width(1'b1, w);
        `CHK(w, 4)
        repeat (10) @(posedge sys_clk);
        #1 c0 = pins.clk[0];
        `CHK(pins.oe_n[2], 1'b1)
        `CHK(pins.clk[2], 1'b0)
        @(posedge sys_clk);
        #1;
        `CHK(pins.clk[0], ~c0)
    endtask

    task automatic t_sleep();
        wr(mk(3'h7, 3'h0, 1'b0, 24'h01_0101));
        drive(3'h7, 1'b0);
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK(active, 1'b0)
        `CHK(pins, 6'h00)
        `CHK(cfg_out, cur)
        drive(3'h7, 1'b1);
        check_outs();
    endtask

    // ==========================================
    // Main sequence and verdict
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        sleep_n = 1'b0;
        gate_pin = 3'h0;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_asleep();
        t_wake();
        t_gating();
        t_diff();
        t_glitch();
        t_sleep();
        summarize();
    end
endmodule
